// [bench/pps_engine_model.sv]
module pps_engine_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request from the port, answer back
  input wire logic xfer_start,
  input wire logic [15:0] rd_word,
  output logic xfer_done,
  output logic [15:0] xfer_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy;
  logic slow;
  logic [3:0] wait_cnt;
  logic [15:0] idle_pat;
  // alternate prompt and slow answers so stalls get exercised
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      slow <= 1'b0;
      wait_cnt <= 4'h0;
      idle_pat <= 16'h0;
      xfer_done <= 1'b0;
    end else begin
      idle_pat <= idle_pat + 16'h3d;
      xfer_done <= 1'b0;
      if (xfer_start) begin
        busy <= 1'b1;
        wait_cnt <= slow ? 4'h6 : 4'h0;
        slow <= !slow;
      end else if (busy && wait_cnt == 4'h0) begin
        busy <= 1'b0;
        xfer_done <= 1'b1;
      end else if (busy) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
  // outside done the bus wanders, so a late sample cannot match by luck
  assign xfer_rdata = xfer_done ? rd_word : idle_pat;
endmodule // pps_engine_model

// [bench/pps_port_props.sv]
module pps_port_props (
  // apb side
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // transaction request
  input wire xfer_start
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed access to the input data word, seen one cycle before a start
  wire data_done = psel && penable && pready && paddr == 12'h004;
  // one completed read of register a
  sequence s_rd(a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  sequence s_setup;
    psel && !penable;
  endsequence
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  setup_answer_a: assert property (s_setup ##0 paddr != 12'h004 |=> pready) else $error("no answer");
  unmapped_err_a: assert property (s_setup ##0 paddr > 12'h014 |=> pslverr && prdata == 32'h0)
    else $error("bad refusal");
  trig_cause_a: assert property (xfer_start |-> $past(data_done)) else $error("stray start");
  trig_single_a: assert property (xfer_start |=> !xfer_start) else $error("start too long");
  data_upper_a: assert property (s_rd(12'h004) |-> prdata[31:16] == 16'h0)
    else $error("data upper bits set");
  stat_pad_a: assert property (s_rd(12'h00c) |-> prdata[31:16] == 16'h0 && prdata[13:12] == 2'h0 &&
    prdata[5:4] == 2'h0) else $error("status spare bits set");
  stat_all_a: assert property (s_rd(12'h00c) |-> prdata[15] == &prdata[11:8] &&
    prdata[7] == &prdata[3:0]) else $error("summary flag wrong");
  pin_upper_a: assert property (s_rd(12'h008) |-> prdata[31:24] == 8'h0)
    else $error("pin enable upper set");
  write_target_bits_upper_a: assert property (s_rd(12'h010) |-> prdata[31:24] == 8'h0)
    else $error("write target upper set");
endmodule // pps_port_props

bind pps_port pps_port_props i_pps_port_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .xfer_start);

// [bench/tb_top.sv]
`include "pps_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, host_wr = 0, host_rd = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, pin, d;
  logic pready, pslverr, xfer_start, xfer_write, xfer_wide, xfer_done;
  logic [15:0] xfer_wdata, xfer_rdata, rd_word = 16'h0;
  logic [23:0] xfer_addr, pad_owned;
  logic [1:0] pad_select_use, pad_latch_use, host_slot = 2'h0;
  logic [7:0] host_wdata = 8'h0, host_rdata;
  logic [32:0] rv[$], rm[$];
  logic [17:0] xv[$], xm[$];
  int n_mismatch = 0, check_count = 0;
  pps_port i_pps_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .xfer_start, .xfer_write, .xfer_wide, .xfer_wdata, .xfer_addr, .xfer_done, .xfer_rdata, .pad_owned,
    .pad_select_use, .pad_latch_use, .host_wr, .host_rd, .host_slot, .host_wdata, .host_rdata);
  pps_engine_model i_pps_engine_model (.pclk, .presetn, .xfer_start, .rd_word, .xfer_done, .xfer_rdata);
  // free running clock
  initial forever #50 pclk = ~pclk;
  task automatic cmp(input logic [32:0] got, exp, msk);
    check_count++;
    if ((got & msk) !== (exp & msk)) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_x(input logic [17:0] got, exp, msk);
    cmp(33'(got), 33'(exp), 33'(msk));
  endtask
  task automatic wrap_up;
    if (xv.size() != 0) n_mismatch++;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // request held until pready is seen; reads and refusals leave a note
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v, input logic [32:0] e, m);
    int n;
    if (!wr || e[32]) begin
      rv.push_back(e);
      rm.push_back(m);
    end
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    apb(1'b1, a, v, 33'h0, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
    apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
  endtask
  // a read with chk low is an underflow probe whose byte is meaningless
  task automatic host(input logic w, input logic [1:0] s, input logic [7:0] v, input logic chk);
    @(posedge pclk);
    host_wr <= w; host_rd <= !w; host_slot <= s; host_wdata <= v;
    @(posedge pclk);
    host_wr <= 1'b0; host_rd <= 1'b0;
    @(negedge pclk);
    if (!w && chk) cmp(33'(host_rdata), 33'(v), 33'hff);
  endtask
  // completed reads and refusals, and started transactions, are matched against notes
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && (!pwrite || pslverr === 1'b1)) begin
      if (rv.size() != 0) cmp({pslverr, prdata}, rv.pop_front(), rm.pop_front());
      else n_mismatch++;
    end
    if (xfer_start === 1'b1) begin
      if (xv.size() != 0) cmp_x({xfer_write, xfer_wide, xfer_wdata}, xv.pop_front(), xm.pop_front());
      else n_mismatch++;
    end
  end
  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    wrap_up;
  end
  initial begin
    void'($urandom(32'h7cd1a975));
    pin = ($urandom() & 32'h00ff_ffff) | 32'h0000_c000;
    d = $urandom();
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`PPS_ADDR_STAT, `PPS_STAT_RESET);
    rd(`PPS_ADDR_INDATA, 32'h0);
    apb(1'b0, 12'h018, 32'h0, {1'b1, 32'h0}, {33{1'b1}});
    wr(`PPS_ADDR_PINEN, pin);
    rd(`PPS_ADDR_PINEN, pin);
    for (int c = 0; c < 3; c++) begin
      wr(`PPS_ADDR_CTRL, 32'h1800 | (c << 6));
      // pad outputs follow the control write by one registered cycle
      @(posedge pclk);
      @(negedge pclk);
      cmp(33'({pad_select_use, pad_owned}), 33'({c != 0, c == 2, 8'h0, pin[15:0]}), {33{1'b1}});
    end
    wr(`PPS_ADDR_CTRL, 32'h1_1b00);
    @(posedge pclk);
    @(negedge pclk);
    cmp(33'({pad_latch_use, pad_owned}), 33'({pin[1:0], pin[23:0]}), {33{1'b1}});
    wr(`PPS_ADDR_CTRL, 32'h1c00);
    xv.push_back({2'b11, d[15:0]}); xm.push_back(18'h3ffff);
    wr(`PPS_ADDR_INDATA, {16'h0, d[15:0]});
    rd_word <= d[31:16];
    xv.push_back({2'b01, 16'h0}); xm.push_back(18'h30000);
    xv.push_back({2'b01, 16'h0}); xm.push_back(18'h30000);
    rd(`PPS_ADDR_INDATA, {16'h0, d[15:0]});
    rd(`PPS_ADDR_INDATA, {16'h0, d[31:16]});
    wr(`PPS_ADDR_CTRL, 32'h1800);
    xv.push_back({2'b10, 8'h0, d[7:0]}); xm.push_back(18'h3ffff);
    wr(`PPS_ADDR_INDATA, {24'h0, d[7:0]});
    wr(`PPS_ADDR_CTRL, 32'h2_1800);
    wr(`PPS_ADDR_INDATA, 32'h55aa);
    wr(`PPS_ADDR_WRITE_TARGET_BITS, pin);
    rd(`PPS_ADDR_WRITE_TARGET_BITS, pin);
    @(negedge pclk);
    cmp(33'(xfer_addr), 33'(pin[23:0]), {33{1'b1}});
    wr(`PPS_ADDR_CTRL, 32'h0800);
    for (int s = 0; s < 4; s++) host(1'b1, 2'(s), 8'(8'h10 + s), 1'b0);
    rd(`PPS_ADDR_STAT, 32'h8f8f);
    host(1'b1, 2'h0, 8'h77, 1'b0);
    rd(`PPS_ADDR_STAT, 32'hcf8f);
    wr(`PPS_ADDR_STAT, 32'h4040);
    rd(`PPS_ADDR_STAT, 32'hcf8f);
    wr(`PPS_ADDR_STAT, 32'h0);
    rd(`PPS_ADDR_INDATA, 32'h0, 32'h0);
    rd(`PPS_ADDR_STAT, 32'h008f);
    wr(`PPS_ADDR_OUTBUF, 32'h4433_2211);
    rd(`PPS_ADDR_STAT, 32'h0);
    for (int s = 0; s < 4; s++) host(1'b0, 2'(s), 8'(8'h11 * (s + 1)), 1'b1);
    rd(`PPS_ADDR_STAT, 32'h008f);
    host(1'b0, 2'h0, 8'h0, 1'b0);
    rd(`PPS_ADDR_STAT, 32'h00cf);
    wr(`PPS_ADDR_STAT, 32'h0);
    rd(`PPS_ADDR_STAT, 32'h008f);
    wrap_up;
  end
endmodule // tb_top

// [core/pps_defines.vh]
`ifndef PPS_DEFINES_VH
`define PPS_DEFINES_VH
// register byte addresses
`define PPS_ADDR_CTRL 12'h000
`define PPS_ADDR_INDATA 12'h004
`define PPS_ADDR_PINEN 12'h008
`define PPS_ADDR_STAT 12'h00c
`define PPS_ADDR_WRITE_TARGET_BITS 12'h010
`define PPS_ADDR_OUTBUF 12'h014
// control register fields
`define PPS_CTRL_CSF_HI 7
`define PPS_CTRL_CSF_LO 6
`define PPS_CTRL_MUX_HI 9
`define PPS_CTRL_MUX_LO 8
`define PPS_CTRL_WIDE 10
`define PPS_CTRL_MODE_HI 12
`define PPS_CTRL_MODE_LO 11
`define PPS_CTRL_EXTENDED_ADDRESS_SETTING 16
`define PPS_CTRL_SPLIT 17
`define PPS_CTRL_MASK 32'h0003_1fc0
// port modes
`define PPS_MODE_MASTER 2'h3
`define PPS_MODE_ESLAVE 2'h1
// status fields
`define PPS_ST_IFULL 15
`define PPS_ST_IOVF 14
`define PPS_ST_OEMPTY 7
`define PPS_ST_OUNDF 6
`define PPS_STAT_RESET 32'h0000_008f
`define PPS_PINEN_MASK 32'h00ff_ffff
`define PPS_WRITE_TARGET_BITS_MASK 32'h00ff_ffff
`endif

// [core/pps_port.v]
`include "pps_defines.vh"
module pps_port (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // master-mode transaction request to the strobe engine
  output reg xfer_start,
  output reg xfer_write,
  output reg xfer_wide,
  output reg [15:0] xfer_wdata,
  output reg [23:0] xfer_addr,
  input wire xfer_done,
  input wire [15:0] xfer_rdata,
  // pad ownership, one bit per address pad
  output reg [23:0] pad_owned,
  output reg [1:0] pad_select_use,
  output reg [1:0] pad_latch_use,
  // external host slave side, byte slot per access
  input wire host_wr,
  input wire host_rd,
  input wire [1:0] host_slot,
  input wire [7:0] host_wdata,
  output reg [7:0] host_rdata
);

  reg [31:0] port_control_reg;
  reg [15:0] input_data_reg;
  reg [23:0] pin_enable_reg;
  reg [23:0] write_target_address_reg;
  reg [3:0] in_full_reg;
  reg [3:0] out_empty_reg;
  reg ovf_reg;
  reg unf_reg;
  reg [7:0] in_buf [0:3];
  reg [7:0] out_buf [0:3];
  reg busy_reg;
  reg [31:0] rd_mux;
  reg [31:0] stat_word;

  wire [1:0] mode = port_control_reg[`PPS_CTRL_MODE_HI:`PPS_CTRL_MODE_LO];
  wire master = (mode == `PPS_MODE_MASTER);
  wire wide = port_control_reg[`PPS_CTRL_WIDE];
  wire split = port_control_reg[`PPS_CTRL_SPLIT];
  wire extended_address_setting = port_control_reg[`PPS_CTRL_EXTENDED_ADDRESS_SETTING];
  wire [1:0] select_function_field = port_control_reg[`PPS_CTRL_CSF_HI:`PPS_CTRL_CSF_LO];
  wire [1:0] amux = port_control_reg[`PPS_CTRL_MUX_HI:`PPS_CTRL_MUX_LO];
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready;
  wire wr_acc = acc & pwrite;
  wire rd_acc = acc & ~pwrite;

  // address match helper, used by every decode
  function hit;
    input [11:0] a;
    input [11:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  // master-mode trigger; host slots belong to the slave modes only
  wire trig_ok = master & ~split & ~busy_reg;
  wire trig_wr = wr_acc & hit(paddr, `PPS_ADDR_INDATA) & trig_ok;
  wire trig_rd = rd_acc & hit(paddr, `PPS_ADDR_INDATA) & trig_ok;
  wire slave = ~master;
  wire hwr = host_wr & slave;
  wire hrd = host_rd & slave;
  wire sw_in_rd = rd_acc & hit(paddr, `PPS_ADDR_INDATA) & slave;
  wire sw_out_wr = wr_acc & hit(paddr, `PPS_ADDR_OUTBUF) & slave;
  wire sw_stat_wr = wr_acc & hit(paddr, `PPS_ADDR_STAT);

  // apb answers in the access cycle; wait only while a port transfer runs
  always @* begin
    rd_mux = 32'h0000_0000;
    stat_word = 32'h0000_0000;
    stat_word[`PPS_ST_IFULL] = &in_full_reg;
    stat_word[`PPS_ST_IOVF] = ovf_reg;
    stat_word[11:8] = in_full_reg;
    stat_word[`PPS_ST_OEMPTY] = &out_empty_reg;
    stat_word[`PPS_ST_OUNDF] = unf_reg;
    stat_word[3:0] = out_empty_reg;
    if (hit(paddr, `PPS_ADDR_CTRL)) begin
      rd_mux = port_control_reg;
    end else if (hit(paddr, `PPS_ADDR_INDATA)) begin
      rd_mux = {16'h0000, input_data_reg};
    end else if (hit(paddr, `PPS_ADDR_PINEN)) begin
      rd_mux = {8'h00, pin_enable_reg};
    end else if (hit(paddr, `PPS_ADDR_STAT)) begin
      rd_mux = stat_word;
    end else if (hit(paddr, `PPS_ADDR_WRITE_TARGET_BITS)) begin
      rd_mux = {8'h00, write_target_address_reg};
    end else if (hit(paddr, `PPS_ADDR_OUTBUF)) begin
      rd_mux = {out_buf[3], out_buf[2], out_buf[1], out_buf[0]};
    end
  end

  wire mapped = hit(paddr, `PPS_ADDR_CTRL) | hit(paddr, `PPS_ADDR_INDATA) | hit(paddr, `PPS_ADDR_PINEN) |
    hit(paddr, `PPS_ADDR_STAT) | hit(paddr, `PPS_ADDR_WRITE_TARGET_BITS) | hit(paddr, `PPS_ADDR_OUTBUF);
  // a trigger access stalls until the port engine is idle, so none is dropped
  wire stall = hit(paddr, `PPS_ADDR_INDATA) & master & ~split & busy_reg;

  // bus handshake and read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (psel & ~pready & (setup | penable) & ~stall) begin
        pready <= 1'b1;
        pslverr <= ~mapped;
        prdata <= mapped ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // software-written configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_control_reg <= 32'h0000_0000;
      pin_enable_reg <= 24'h00_0000;
      write_target_address_reg <= 24'h00_0000;
    end else if (wr_acc) begin
      if (hit(paddr, `PPS_ADDR_CTRL)) begin
        port_control_reg <= pwdata & `PPS_CTRL_MASK;
      end
      if (hit(paddr, `PPS_ADDR_PINEN)) begin
        pin_enable_reg <= pwdata[23:0]; // upper bits dropped
      end
      if (hit(paddr, `PPS_ADDR_WRITE_TARGET_BITS)) begin
        write_target_address_reg <= pwdata[23:0];
      end
    end
  end

  // input data: software writes, or read data returned by the port
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_data_reg <= 16'h0000;
    end else if (busy_reg & xfer_done & ~xfer_write) begin
      input_data_reg <= wide ? xfer_rdata : {8'h00, xfer_rdata[7:0]};
    end else if (wr_acc & hit(paddr, `PPS_ADDR_INDATA)) begin
      input_data_reg <= wide ? pwdata[15:0] : {8'h00, pwdata[7:0]};
    end
  end

  // transaction launch: one pulse per trigger access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_start <= 1'b0;
      xfer_write <= 1'b0;
      xfer_wide <= 1'b0;
      xfer_wdata <= 16'h0000;
      busy_reg <= 1'b0;
    end else begin
      xfer_start <= 1'b0;
      if (busy_reg & xfer_done) begin
        busy_reg <= 1'b0;
      end
      // a data word write in master mode with split off is a trigger in either width; narrow mode sends only the low byte
      if (trig_wr & (wide ? 1'b1 : 1'b1)) begin
        xfer_start <= 1'b1;
        xfer_write <= 1'b1;
        xfer_wide <= wide;
        xfer_wdata <= wide ? pwdata[15:0] : {8'h00, pwdata[7:0]};
        busy_reg <= 1'b1;
      end else if (trig_rd) begin
        xfer_start <= 1'b1;
        xfer_write <= 1'b0;
        xfer_wide <= wide;
        busy_reg <= 1'b1;
      end
    end
  end

  // target address: write target register only counts when split buffers are on
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_addr <= 24'h00_0000;
    end else begin
      xfer_addr <= split ? write_target_address_reg : 24'h00_0000;
    end
  end

  // pad ownership from pin enables and control fields
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_owned <= 24'h00_0000;
      pad_select_use <= 2'b00;
      pad_latch_use <= 2'b00;
    end else begin
      pad_owned[23:16] <= (master & extended_address_setting) ? pin_enable_reg[23:16] : 8'h00;
      pad_owned[15:14] <= pin_enable_reg[15:14];
      pad_owned[13:2] <= pin_enable_reg[13:2];
      pad_owned[1:0] <= pin_enable_reg[1:0];
      // csf 00 keeps address, 01 uses bit 15 as select, 10 uses both
      pad_select_use[1] <= pin_enable_reg[15] & (select_function_field != 2'b00);
      pad_select_use[0] <= pin_enable_reg[14] & (select_function_field == 2'b10);
      pad_latch_use <= pin_enable_reg[1:0] & {2{amux != 2'b00}};
    end
  end

  // slave byte buffers and status flags; hardware set wins over software clear
  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_full_reg <= 4'h0;
      out_empty_reg <= 4'hf;
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
      host_rdata <= 8'h00;
      for (i = 0; i < 4; i = i + 1) begin
        in_buf[i] <= 8'h00;
        out_buf[i] <= 8'h00;
      end
    end else begin
      // software clears by writing zero; writing one has no effect
      if (sw_stat_wr & ~pwdata[`PPS_ST_IOVF]) begin
        ovf_reg <= 1'b0;
      end
      if (sw_stat_wr & ~pwdata[`PPS_ST_OUNDF]) begin
        unf_reg <= 1'b0;
      end
      if (sw_in_rd) begin
        in_full_reg <= 4'h0;
      end
      if (sw_out_wr) begin
        out_empty_reg <= 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
          out_buf[i] <= pwdata[8*i +: 8];
        end
      end
      if (hwr) begin
        if (in_full_reg[host_slot]) begin
          ovf_reg <= 1'b1;
        end else begin
          in_buf[host_slot] <= host_wdata;
          in_full_reg[host_slot] <= 1'b1;
        end
      end
      if (hrd) begin
        host_rdata <= out_buf[host_slot];
        if (out_empty_reg[host_slot]) begin
          unf_reg <= 1'b1;
        end else begin
          out_empty_reg[host_slot] <= 1'b1; // sent
        end
      end
    end
  end

endmodule // pps_port
